// File: rtl/vme_system_interrupt_control.sv
// Purpose: Gathers system and VMEbus interrupt sources onto seven processor levels.
// Assumes: Single clock mclk at 50 MHz; rst and por synchronous, active high, from on-chip logic.
// Notes: Register port is a simple odd-byte strobe port answered one cycle later.
`timescale 1ns/100ps
`include "sys_irq_consts.svh"

module vme_system_interrupt_control
(
  // Clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic por,
  // Processor register port
  input wire logic cpu_sel,
  input wire logic cpu_wr,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_ack,
  // System interrupt sources, asynchronous
  input wire logic sysfail,
  input wire logic multifunction_peripheral_irq,
  input wire logic serial_comm_controller_irq,
  input wire logic vsync,
  input wire logic hsync,
  // VMEbus interrupt lines, active high, asynchronous
  input wire logic [7:1] vme_irq,
  output logic vme_irq3_out,
  // Processor priority and acknowledge
  output logic [2:0] ipl,
  input wire logic iack_req,
  input wire logic [2:0] iack_level,
  output logic iack_done,
  output logic iack_autovec,
  output logic iack_periph,
  output logic [7:0] iack_vector,
  // VMEbus interrupt acknowledge
  output logic vme_iack_req,
  output logic [2:0] vme_iack_level,
  input wire logic vme_status_valid,
  input wire logic [7:0] vme_status
);

  // ==========================================================================
  // State
  sys_irq_pkg::ctl_state_type s;
  sys_irq_pkg::ctl_state_type next_s;

  logic [`SYNC_W-1:0] raw_in;
  logic [7:0] sys_pending;
  logic [7:0] vme_pending;
  logic [7:1] sys_req;
  logic [7:1] vme_req;
  logic [2:0] top_level;
  logic hit;
  logic [15:0] word_addr;

  // ==========================================================================
  // Source gathering
  assign raw_in = {vme_status_valid, vme_irq, hsync, vsync, serial_comm_controller_irq,
                   multifunction_peripheral_irq, sysfail};

  // Edges of the sync pulses are caught so a short pulse still requests its level.
  always_comb
  begin
    sys_pending = 8'h00;
    sys_pending[`LVL_SYSFAIL] = s.sync[`SYN_SYSFAIL];
    sys_pending[`LVL_MULTI] = s.sync[`SYN_MULTI];
    sys_pending[`LVL_SERIAL] = s.sync[`SYN_SERIAL];
    sys_pending[`LVL_VSYNC] = s.vsync_flag;
    sys_pending[`LVL_VME_SOFT] = s.vme_soft;
    sys_pending[`LVL_HSYNC] = s.hsync_flag;
    sys_pending[`LVL_SOFT] = s.sys_soft;
    vme_pending = {s.sync[`SYN_VME_HI:`SYN_VME_LO], 1'b0};
  end

  // Bit 0 of each mask is never used as an enable.
  assign sys_req = sys_pending[7:1] & s.sys_mask[7:1];

  always_comb
  begin
    vme_req = vme_pending[7:1] & s.vme_mask[7:1];
    vme_req[`LVL_VME_SOFT] = vme_req[`LVL_VME_SOFT] & s.sys_mask[`LVL_VME_SOFT];
  end

  level_encoder u_level
  (
    .req(sys_req | vme_req),
    .level(top_level)
  );

  // ==========================================================================
  // Register decode
  assign word_addr = {cpu_addr[15:1], 1'b0};
  assign hit = cpu_sel && (cpu_addr >= `OFS_BLOCK_BASE) && (cpu_addr <= `OFS_BLOCK_LAST);

  // ==========================================================================
  // Next state
  always_comb
  begin
    next_s = s;

    // Two stages before any logic looks at an outside level.
    next_s.meta = raw_in;
    next_s.sync = s.meta;
    next_s.vsync_prev = s.sync[`SYN_VSYNC];
    next_s.hsync_prev = s.sync[`SYN_HSYNC];

    // Request shown until withdrawn; it follows the live request each cycle.
    next_s.ipl = top_level;
    next_s.vme_irq3 = s.vme_soft;

    // Register access.
    next_s.rack = 1'b0;
    next_s.rdata = s.rdata;
    if (hit)
    begin
      next_s.rack = 1'b1;
      if (cpu_wr)
      begin
        unique case (word_addr)
          `OFS_SYSTEM_IRQ_MASK: next_s.sys_mask = cpu_wdata;
          `OFS_SYSTEM_SOFT_IRQ: next_s.sys_soft = cpu_wdata[`BIT_SOFT_GO];
          `OFS_VME_SOFT_IRQ: next_s.vme_soft = cpu_wdata[`BIT_SOFT_GO];
          `OFS_SCRATCH_ONE: next_s.scratch_one = cpu_wdata;
          `OFS_SCRATCH_TWO: next_s.scratch_two = cpu_wdata;
          `OFS_VME_IRQ_MASK: next_s.vme_mask = cpu_wdata;
          `OFS_SYSTEM_IRQ_PENDING: next_s.rack = 1'b1;
          `OFS_VME_IRQ_PENDING: next_s.rack = 1'b1;
          default: next_s.rack = 1'b1;
        endcase
      end
      else
      begin
        unique case (word_addr)
          `OFS_SYSTEM_IRQ_MASK: next_s.rdata = s.sys_mask;
          `OFS_SYSTEM_IRQ_PENDING: next_s.rdata = sys_pending;
          `OFS_SYSTEM_SOFT_IRQ: next_s.rdata = {7'h00, s.sys_soft};
          `OFS_VME_SOFT_IRQ: next_s.rdata = {7'h00, s.vme_soft};
          `OFS_SCRATCH_ONE: next_s.rdata = s.scratch_one;
          `OFS_SCRATCH_TWO: next_s.rdata = s.scratch_two;
          `OFS_VME_IRQ_MASK: next_s.rdata = s.vme_mask;
          `OFS_VME_IRQ_PENDING: next_s.rdata = vme_pending;
          default: next_s.rdata = `RST_BYTE;
        endcase
      end
    end

    // Acknowledge sequence.
    next_s.answer.done = 1'b0;
    unique case (s.ack_state)
      sys_irq_pkg::ack_idle:
      begin
        if (iack_req)
        begin
          next_s.ack_level = iack_level;
          if (sys_req[iack_level] && (iack_level != `LVL_NONE))
          begin
            // System source wins its level over the VMEbus request.
            next_s.answer.done = 1'b1;
            next_s.answer.vector = `RST_BYTE;
            // Peripherals on levels 5 and 6 put their own vector on the bus.
            if ((iack_level == `LVL_MULTI) || (iack_level == `LVL_SERIAL))
            begin
              next_s.answer.autovec = 1'b0;
              next_s.answer.periph = 1'b1;
            end
            else
            begin
              next_s.answer.autovec = 1'b1;
              next_s.answer.periph = 1'b0;
            end
            next_s.ack_state = sys_irq_pkg::ack_finish;
          end
          else if (vme_req[iack_level] && (iack_level != `LVL_NONE))
          begin
            next_s.vme_iack_req = 1'b1;
            next_s.vme_iack_level = iack_level;
            next_s.ack_state = sys_irq_pkg::ack_vme_wait;
          end
          else
          begin
            // Request vanished before the acknowledge: answer with an autovector.
            next_s.answer.done = 1'b1;
            next_s.answer.autovec = 1'b1;
            next_s.answer.periph = 1'b0;
            next_s.answer.vector = `RST_BYTE;
            next_s.ack_state = sys_irq_pkg::ack_finish;
          end
        end
      end
      sys_irq_pkg::ack_vme_wait:
      begin
        // The status byte was held stable while its valid passed the synchroniser.
        if (s.sync[`SYN_VME_VALID])
        begin
          next_s.vme_iack_req = 1'b0;
          next_s.answer.done = 1'b1;
          next_s.answer.autovec = 1'b0;
          next_s.answer.periph = 1'b0;
          next_s.answer.vector = vme_status;
          next_s.ack_state = sys_irq_pkg::ack_finish;
        end
        else if (!iack_req)
        begin
          // The processor gave up the cycle, so the bus acknowledge is released rather than held forever.
          next_s.vme_iack_req = 1'b0;
          next_s.ack_state = sys_irq_pkg::ack_idle;
        end
      end
      sys_irq_pkg::ack_finish:
      begin
        // Wait for the processor to drop its request before the next cycle.
        if (!iack_req)
        begin
          next_s.ack_state = sys_irq_pkg::ack_idle;
        end
      end
      default:
      begin
        // An upset state code returns to idle instead of hanging the acknowledge.
        next_s.vme_iack_req = 1'b0;
        next_s.ack_state = sys_irq_pkg::ack_idle;
      end
    endcase

    // Sync event flags: a new edge in the clearing cycle wins over the clear.
    if (s.answer.done && s.answer.autovec && (s.ack_level == `LVL_VSYNC))
    begin
      next_s.vsync_flag = 1'b0;
    end
    if (s.answer.done && s.answer.autovec && (s.ack_level == `LVL_HSYNC))
    begin
      next_s.hsync_flag = 1'b0;
    end
    if (s.sync[`SYN_VSYNC] && !s.vsync_prev)
    begin
      next_s.vsync_flag = 1'b1;
    end
    if (s.sync[`SYN_HSYNC] && !s.hsync_prev)
    begin
      next_s.hsync_flag = 1'b1;
    end

    // Ordinary reset leaves the scratch bytes alone; only power-up clears them.
    if (rst || por)
    begin
      next_s.sys_mask = `RST_MASK;
      next_s.vme_mask = `RST_MASK;
      next_s.sys_soft = `RST_SOFT;
      next_s.vme_soft = `RST_SOFT;
      next_s.meta = '0;
      next_s.sync = '0;
      next_s.vsync_prev = 1'b0;
      next_s.hsync_prev = 1'b0;
      next_s.vsync_flag = 1'b0;
      next_s.hsync_flag = 1'b0;
      next_s.ipl = `LVL_NONE;
      next_s.vme_irq3 = 1'b0;
      next_s.rdata = `RST_BYTE;
      next_s.rack = 1'b0;
      next_s.ack_state = sys_irq_pkg::ack_idle;
      next_s.ack_level = `LVL_NONE;
      next_s.answer = '0;
      next_s.vme_iack_req = 1'b0;
      next_s.vme_iack_level = `LVL_NONE;
    end
    if (por)
    begin
      next_s.scratch_one = `RST_BYTE;
      next_s.scratch_two = `RST_BYTE;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge mclk)
  begin
    s <= next_s;
  end

  // ==========================================================================
  // Outputs
  assign cpu_rdata = s.rdata;
  assign cpu_ack = s.rack;
  assign vme_irq3_out = s.vme_irq3;
  assign ipl = s.ipl;
  assign iack_done = s.answer.done;
  assign iack_autovec = s.answer.autovec;
  assign iack_periph = s.answer.periph;
  assign iack_vector = s.answer.vector;
  assign vme_iack_req = s.vme_iack_req;
  assign vme_iack_level = s.vme_iack_level;

endmodule

// File: rtl/sys_irq_consts.svh
// Purpose: Named offsets, field positions, reset values and codes for the system interrupt control.
// Assumes: Register offsets are byte offsets within the local I/O page.
// Notes: Definitions only.
`ifndef SYS_IRQ_CONSTS_SVH
`define SYS_IRQ_CONSTS_SVH

// ==========================================================================
// Register offsets
`define OFS_SYSTEM_IRQ_MASK 16'h8e00
`define OFS_SYSTEM_IRQ_PENDING 16'h8e02
`define OFS_SYSTEM_SOFT_IRQ 16'h8e04
`define OFS_VME_SOFT_IRQ 16'h8e06
`define OFS_SCRATCH_ONE 16'h8e08
`define OFS_SCRATCH_TWO 16'h8e0a
`define OFS_VME_IRQ_MASK 16'h8e0c
`define OFS_VME_IRQ_PENDING 16'h8e0e
`define OFS_BLOCK_BASE 16'h8e00
`define OFS_BLOCK_LAST 16'h8e1f

// ==========================================================================
// Field positions and reset values
`define BIT_SOFT_GO 0
`define RST_MASK 8'h00
`define RST_SOFT 1'b0
`define RST_BYTE 8'h00

// ==========================================================================
// Priority levels
`define LVL_NONE 3'h0
`define LVL_SOFT 3'h1
`define LVL_HSYNC 3'h2
`define LVL_VME_SOFT 3'h3
`define LVL_VSYNC 3'h4
`define LVL_SERIAL 3'h5
`define LVL_MULTI 3'h6
`define LVL_SYSFAIL 3'h7

// ==========================================================================
// Synchroniser bit positions
`define SYNC_W 13
`define SYN_SYSFAIL 0
`define SYN_MULTI 1
`define SYN_SERIAL 2
`define SYN_VSYNC 3
`define SYN_HSYNC 4
`define SYN_VME_LO 5
`define SYN_VME_HI 11
`define SYN_VME_VALID 12

`endif

// File: rtl/sys_irq_pkg.sv
// Purpose: Types shared by the system interrupt control.
// Assumes: Constants come from sys_irq_consts.svh.
// Notes: All module state travels as one packed struct.
`include "sys_irq_consts.svh"

package sys_irq_pkg;

  // ==========================================================================
  // Acknowledge sequence
  typedef enum logic [1:0] {ack_idle, ack_vme_wait, ack_finish} ack_state_type;

  // ==========================================================================
  // Processor acknowledge answer
  typedef struct packed {
    logic done;
    logic autovec;
    logic periph;
    logic [7:0] vector;
  } ack_answer_type;

  // ==========================================================================
  // Whole state of the controller
  typedef struct packed {
    logic [7:0] sys_mask;
    logic [7:0] vme_mask;
    logic sys_soft;
    logic vme_soft;
    logic [7:0] scratch_one;
    logic [7:0] scratch_two;
    logic [`SYNC_W-1:0] meta;
    logic [`SYNC_W-1:0] sync;
    logic vsync_prev;
    logic hsync_prev;
    logic vsync_flag;
    logic hsync_flag;
    logic [2:0] ipl;
    logic vme_irq3;
    logic [7:0] rdata;
    logic rack;
    ack_state_type ack_state;
    logic [2:0] ack_level;
    ack_answer_type answer;
    logic vme_iack_req;
    logic [2:0] vme_iack_level;
  } ctl_state_type;

endpackage

// File: rtl/level_encoder.sv
// Purpose: Finds the highest requesting priority level.
// Assumes: Bit n of req stands for level n; level 0 is no request.
// Notes: Purely combinational.
`timescale 1ns/100ps

module level_encoder
(
  // Requests by level
  input wire logic [7:1] req,
  // Highest active level
  output logic [2:0] level
);

  // ==========================================================================
  // Priority search
  always_comb
  begin
    level = 3'h0;
    for (int i = 1; i <= 7; i++)
    begin
      if (req[i])
      begin
        level = 3'(i);
      end
    end
  end

endmodule

// File: verif/irq_ctl_properties.sv
// Purpose: Port checks for the interrupt control.
// Assumes: Bound to vme_system_interrupt_control.
// Notes: Either reset disables every check.
`timescale 1ns/100ps
module irq_ctl_properties
(
  // Watched ports
  input wire logic mclk,
  input wire logic rst,
  input wire logic por,
  input wire logic cpu_sel,
  input wire logic cpu_wr,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_ack,
  input wire logic [2:0] ipl,
  input wire logic vme_irq3_out,
  input wire logic iack_req,
  input wire logic [2:0] iack_level,
  input wire logic iack_done,
  input wire logic iack_autovec,
  input wire logic iack_periph,
  input wire logic [7:0] iack_vector,
  input wire logic vme_iack_req,
  input wire logic [2:0] vme_iack_level,
  input wire logic vme_status_valid,
  input wire logic [7:0] vme_status
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst || por);
  logic hit;
  assign hit = cpu_sel && cpu_addr[15:5] == 11'h470;
  // ==========================================================================
  // Checks
  bus_ack_a: assert property (hit |=> cpu_ack)
    else $error("access not acknowledged");
  bus_refuse_a: assert property (!hit |=> !cpu_ack)
    else $error("acknowledge without access");
  unmapped_zero_a: assert property (hit && !cpu_wr && cpu_addr[4] |=> cpu_rdata == 8'h00)
    else $error("unmapped read not zero");
  irq3_set_a: assert property (hit && cpu_wr && cpu_addr[4:1] == 4'h3 && cpu_wdata[0] |-> ##2 vme_irq3_out)
    else $error("bus line three not raised");
  irq3_clear_a: assert property (hit && cpu_wr && cpu_addr[4:1] == 4'h3 && !cpu_wdata[0] |-> ##2 !vme_irq3_out)
    else $error("bus line three not withdrawn");
  done_pulse_a: assert property (iack_done |=> !iack_done)
    else $error("acknowledge answer longer than one cycle");
  vme_vector_a: assert property (iack_done && !iack_autovec && !iack_periph |-> iack_vector == $past(vme_status))
    else $error("vector differs from status byte");
  vme_start_a: assert property ($rose(vme_iack_req) |-> $past(iack_req) && vme_iack_level == $past(iack_level))
    else $error("bus acknowledge without processor acknowledge");
  vme_done_a: assert property ($rose(vme_status_valid) && vme_iack_req |-> ##[1:4] (iack_done && !iack_autovec))
    else $error("status byte not passed on");
  cover property (iack_done && iack_periph);
  cover property (iack_done && !iack_autovec && !iack_periph);
  cover property (ipl == 3'h7);
endmodule

bind vme_system_interrupt_control irq_ctl_properties irq_ctl_properties_inst
(
  .mclk(mclk), .rst(rst), .por(por), .cpu_sel(cpu_sel), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
  .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .ipl(ipl), .vme_irq3_out(vme_irq3_out),
  .iack_req(iack_req), .iack_level(iack_level), .iack_done(iack_done), .iack_autovec(iack_autovec),
  .iack_periph(iack_periph), .iack_vector(iack_vector), .vme_iack_req(vme_iack_req),
  .vme_iack_level(vme_iack_level), .vme_status_valid(vme_status_valid), .vme_status(vme_status)
);

// File: verif/vme_requester_model.sv
// Purpose: Bus interrupter that answers an acknowledge with a status byte.
// Assumes: The status byte depends only on the acknowledged level.
// Notes: Released status lines show the inverse of the last byte.
`timescale 1ns/100ps
module vme_requester_model
#(
  parameter logic [7:0] status_base = 8'ha0
)
(
  // Clock and pace
  input wire logic mclk,
  input wire logic slow,
  // Acknowledge from the controller
  input wire logic vme_iack_req,
  input wire logic [2:0] vme_iack_level,
  // Status answer
  output logic vme_status_valid,
  output logic [7:0] vme_status
);
  logic valid_q = 1'b0;
  logic [7:0] status_q = 8'h00;
  int cnt = 0;
  assign vme_status_valid = valid_q;
  assign vme_status = status_q;
  always @(posedge mclk)
  begin
    if (vme_iack_req !== 1'b1)
    begin
      cnt <= 0;
      if (valid_q)
      begin
        valid_q <= 1'b0;
        status_q <= ~status_q;
      end
    end
    else if (cnt < (slow ? 6 : 0))
      cnt <= cnt + 1;
    else
    begin
      valid_q <= 1'b1;
      status_q <= status_base | {5'h00, vme_iack_level};
    end
  end
endmodule

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the interrupt control.
// Assumes: Inputs change on the falling edge of mclk.
// Notes: Register rows first, then hand-written cases.
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_type;
  logic mclk = 1'b0, rst = 1'b1, por = 1'b1, cpu_sel = 1'b0, cpu_wr = 1'b0, iack_req = 1'b0, slow = 1'b0;
  logic sysfail = 1'b0, periph_irq = 1'b0, serial_irq = 1'b0, vsync = 1'b0, hsync = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:1] vme_irq = 7'h00;
  logic [2:0] iack_level = 3'h0;
  logic [7:0] cpu_rdata, iack_vector, vme_status, q;
  logic cpu_ack, vme_irq3_out, iack_done, iack_autovec, iack_periph, vme_iack_req, vme_status_valid;
  logic [2:0] ipl, vme_iack_level;
  int n_mismatch = 0, tests_run = 0, cycles = 0;
  row_type rows [7] = '{'{16'h8e00, 8'hfe, 8'hfe}, '{16'h8e0c, 8'hfe, 8'hfe}, '{16'h8e08, 8'h5a, 8'h5a},
    '{16'h8e0a, 8'hc3, 8'hc3}, '{16'h8e02, 8'hff, 8'h00}, '{16'h8e0e, 8'hff, 8'h00}, '{16'h8e12, 8'hff, 8'h00}};

  vme_system_interrupt_control vme_system_interrupt_control_inst
  (
    .mclk(mclk), .rst(rst), .por(por), .cpu_sel(cpu_sel), .cpu_wr(cpu_wr), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack), .sysfail(sysfail),
    .multifunction_peripheral_irq(periph_irq), .serial_comm_controller_irq(serial_irq), .vsync(vsync),
    .hsync(hsync), .vme_irq(vme_irq), .vme_irq3_out(vme_irq3_out), .ipl(ipl), .iack_req(iack_req),
    .iack_level(iack_level), .iack_done(iack_done), .iack_autovec(iack_autovec), .iack_periph(iack_periph),
    .iack_vector(iack_vector), .vme_iack_req(vme_iack_req), .vme_iack_level(vme_iack_level),
    .vme_status_valid(vme_status_valid), .vme_status(vme_status)
  );
  vme_requester_model vme_requester_model_inst
  (
    .mclk(mclk), .slow(slow), .vme_iack_req(vme_iack_req), .vme_iack_level(vme_iack_level),
    .vme_status_valid(vme_status_valid), .vme_status(vme_status)
  );

  initial
  begin
    forever #10 mclk = ~mclk;
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    cpu_sel = 1'b1;
    cpu_wr = w;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge mclk);
    cpu_sel = 1'b0;
    chk({7'h00, cpu_ack}, 8'h01);
    q = cpu_rdata;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task automatic lvl(input logic [2:0] e);
    repeat (4) @(negedge mclk);
    chk({5'h00, ipl}, {5'h00, e});
  endtask
  // Flags are {autovector, peripheral} in the low two bits.
  task automatic ack(input logic [2:0] l, input logic [7:0] f, input logic [7:0] v);
    int i;
    @(negedge mclk);
    iack_req = 1'b1;
    iack_level = l;
    for (i = 0; i < 40 && iack_done !== 1'b1; i++)
      @(negedge mclk);
    chk({7'h00, iack_done}, 8'h01);
    chk({6'h00, iack_autovec, iack_periph}, f);
    chk(iack_vector, v);
    iack_req = 1'b0;
    @(negedge mclk);
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Sequence
  initial
  begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    por = 1'b0;
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    bus(1'b1, 16'h8e04, 8'h01);
    lvl(3'h1);
    rd(16'h8e02, 8'h02);
    ack(3'h1, 8'h02, 8'h00);
    bus(1'b1, 16'h8e04, 8'h00);
    lvl(3'h0);
    bus(1'b1, 16'h8e06, 8'h01);
    @(negedge mclk);
    chk({7'h00, vme_irq3_out}, 8'h01);
    lvl(3'h3);
    rd(16'h8e02, 8'h08);
    bus(1'b1, 16'h8e00, 8'hf6);
    vme_irq = 7'h04;
    lvl(3'h0);
    bus(1'b1, 16'h8e00, 8'hfe);
    bus(1'b1, 16'h8e06, 8'h00);
    @(negedge mclk);
    chk({7'h00, vme_irq3_out}, 8'h00);
    lvl(3'h3);
    ack(3'h3, 8'h00, 8'ha3);
    slow = 1'b1;
    ack(3'h3, 8'h00, 8'ha3);
    bus(1'b1, 16'h8e0c, 8'h00);
    vme_irq = 7'h44;
    lvl(3'h0);
    rd(16'h8e0e, 8'h88);
    bus(1'b1, 16'h8e0c, 8'hfe);
    sysfail = 1'b1;
    lvl(3'h7);
    ack(3'h7, 8'h02, 8'h00);
    sysfail = 1'b0;
    lvl(3'h7);
    ack(3'h7, 8'h00, 8'ha7);
    vme_irq = 7'h20;
    periph_irq = 1'b1;
    lvl(3'h6);
    ack(3'h6, 8'h01, 8'h00);
    periph_irq = 1'b0;
    vme_irq = 7'h10;
    serial_irq = 1'b1;
    lvl(3'h5);
    ack(3'h5, 8'h01, 8'h00);
    serial_irq = 1'b0;
    vme_irq = 7'h00;
    hsync = 1'b1;
    lvl(3'h2);
    ack(3'h2, 8'h02, 8'h00);
    lvl(3'h0);
    vsync = 1'b1;
    lvl(3'h4);
    ack(3'h4, 8'h02, 8'h00);
    rst = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    rd(16'h8e08, 8'h5a);
    rd(16'h8e00, 8'h00);
    por = 1'b1;
    repeat (4) @(negedge mclk);
    por = 1'b0;
    rd(16'h8e0a, 8'h00);
    wrap_up();
  end
endmodule
